//--- hw/vps_pkg.sv
// constants shared by the vector pattern sequencer files
`default_nettype none
package vps_pkg;
    // ---------------------------------------------------------------
    // pattern memory geometry
    // ---------------------------------------------------------------
    localparam int ADDR_W = 18;                  // 256K vector locations
    localparam int BANKS = 5;                    // banks side by side
    localparam int BANK_W = 16;                  // bits per bank
    localparam int WORD_W = BANKS * BANK_W;      // one stored vector word
    localparam int CHANNELS = 32;                // output channels
    // ---------------------------------------------------------------
    // clock rates and selects
    // ---------------------------------------------------------------
    localparam int SRC_MHZ = 200;                // internal source rate
    localparam int MID_MHZ = 100;                // first divided rate
    localparam int LOW_MHZ = 50;                 // second divided rate
    localparam int DIV_MID = SRC_MHZ / MID_MHZ;  // source edges per mid tick
    localparam int DIV_LOW = SRC_MHZ / LOW_MHZ;  // source edges per low tick
    localparam int DIV_W = 2;                    // divider counter width
    localparam logic [1:0] RATE_SRC = 2'h0;      // full internal rate
    localparam logic [1:0] RATE_MID = 2'h1;      // half rate
    localparam logic [1:0] RATE_LOW = 2'h2;      // quarter rate
    localparam logic [1:0] RATE_EXT = 2'h3;      // external clock pin
    localparam int TAPS = 8;                     // clock out delay taps
    localparam int TAP_W = 3;                    // delay select width
    localparam logic [1:0] FILL_MAX = 2'h2;      // output buffer entries
    // ---------------------------------------------------------------
    // sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [0:0] {ST_IDLE, ST_RUN} vps_state_e;
endpackage
`default_nettype wire

//--- hw/vps_mem_if.sv
// port bundle between the sequencer and its pattern memory
`timescale 1ns/1ps
`default_nettype none
interface vps_mem_if;
    logic wr_en;                                 // host write strobe
    logic [vps_pkg::ADDR_W-1:0] wr_addr;         // host write address
    logic [vps_pkg::WORD_W-1:0] wr_data;         // host write word
    logic rd_en;                                 // playback read strobe
    logic [vps_pkg::ADDR_W-1:0] rd_addr;         // playback read address
    logic [vps_pkg::WORD_W-1:0] rd_data;         // registered read word
    modport ctl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface
`default_nettype wire

//--- hw/vps_mem.sv
// pattern memory: one write port, one registered read port
`timescale 1ns/1ps
`default_nettype none
module vps_mem #(
    parameter int DEPTH = 2 ** vps_pkg::ADDR_W
) (
    input wire logic clk,                        // system clock
    vps_mem_if.mem port                          // access bundle
);
    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic [vps_pkg::WORD_W-1:0] store [DEPTH];   // vector words
    logic [vps_pkg::WORD_W-1:0] rd_data_r;       // read data register

    // writes and reads both land on the clock; no reset on the array
    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            store[port.wr_addr] <= port.wr_data;
        end
        if (port.rd_en) begin
            rd_data_r <= store[port.rd_addr];
        end
    end

    assign port.rd_data = rd_data_r;
endmodule
`default_nettype wire

//--- hw/vps_sequencer.sv
// vector pattern sequencer: playback counter, loop, rate and clock out
`timescale 1ns/1ps
`default_nettype none
module vps_sequencer #(
    parameter int CH = vps_pkg::CHANNELS        // channel count
) (
    input wire logic clk,                                 // system clock
    input wire logic rst_b,                               // async reset, low
    input wire logic prog_we,                             // host memory write
    input wire logic [vps_pkg::ADDR_W-1:0] prog_addr,     // host write address
    input wire logic [vps_pkg::WORD_W-1:0] prog_data,     // host write word
    input wire logic run,                                 // play while high
    input wire logic [vps_pkg::ADDR_W-1:0] start_addr,    // listing first vector
    input wire logic [vps_pkg::ADDR_W-1:0] end_addr,      // listing last vector
    input wire logic [vps_pkg::ADDR_W-1:0] loop_addr,     // vector after the last
    input wire logic [1:0] rate_sel,                      // clock select
    input wire logic [vps_pkg::TAP_W-1:0] delay_sel,      // clock out tap
    input wire logic [CH-1:0] chan_en,                    // channel output enables
    input wire logic ext_clk,                             // external clock pin
    input wire logic out_ready,                           // receiver takes vector
    output logic out_valid,                               // vector on out_data
    output logic [CH-1:0] out_data,                       // channel outputs
    output logic clk_out,                                 // delayed clock out
    output logic busy                                     // playback active
);
    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    vps_mem_if mif ();                                    // memory bundle
    vps_pkg::vps_state_e state_r, state_nxt;              // run state
    logic [vps_pkg::ADDR_W-1:0] addr_r, addr_nxt;         // address counter
    logic [vps_pkg::ADDR_W-1:0] loop_r, loop_nxt;         // loop register
    logic [vps_pkg::DIV_W-1:0] div_r, div_nxt;            // rate divider
    logic [2:0] ext_r, ext_nxt;                           // ext sync + edge
    logic [vps_pkg::TAPS-1:0] tap_r, tap_nxt;             // delay taps
    logic clk_out_r, clk_out_nxt;                         // clock out flop
    logic pend_r, pend_nxt;                               // read in flight
    logic [1:0] cnt_r, cnt_nxt;                           // buffer fill
    logic [CH-1:0] e0_r, e0_nxt;                          // head (output)
    logic [CH-1:0] e1_r, e1_nxt;                          // second entry
    logic busy_r, busy_nxt;                               // busy flop
    logic valid_r, valid_nxt;                             // output valid flop
    logic tick;                                           // selected rate pulse
    logic pop;                                            // receiver takes head
    logic [1:0] cnt_pop;                                  // fill after pop
    logic room;                                           // space for a read
    logic step;                                           // counter advances
    logic at_end;                                         // counter at last

    // per-channel output mux: a disabled channel idles low
    function automatic logic [CH-1:0] chan_mux(input logic [vps_pkg::WORD_W-1:0] w,
                                               input logic [CH-1:0] en);
        logic [CH-1:0] o;
        o = '0;
        for (int c = 0; c < CH; c++) begin
            o[c] = en[c] ? w[c] : 1'b0;
        end
        return o;
    endfunction

    // ---------------------------------------------------------------
    // pattern memory
    // ---------------------------------------------------------------
    vps_mem vps_mem_i (
        .clk(clk),
        .port(mif)
    );

    // host writes go straight to memory, playback reads by counter
    assign mif.wr_en = prog_we;
    assign mif.wr_addr = prog_addr;
    assign mif.wr_data = prog_data;
    assign mif.rd_en = step;
    assign mif.rd_addr = addr_r;

    // ---------------------------------------------------------------
    // rate selection
    // ---------------------------------------------------------------
    // divider and external edge detect; only stage 1 reads stage 0
    always_comb begin
        div_nxt = div_r + 2'h1;
        ext_nxt = {ext_r[1:0], ext_clk};
        case (rate_sel)
            vps_pkg::RATE_SRC: tick = 1'b1;
            vps_pkg::RATE_MID: tick = (div_r[0] == 1'b0);
            vps_pkg::RATE_LOW: tick = (div_r == 2'h0);
            default: tick = ext_r[1] & ~ext_r[2];
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_r <= '0;
            ext_r <= '0;
        end else begin
            div_r <= div_nxt;
            ext_r <= ext_nxt;
        end
    end

    // ---------------------------------------------------------------
    // sequencing
    // ---------------------------------------------------------------
    assign pop = out_valid & out_ready;
    assign cnt_pop = cnt_r - {1'b0, pop};
    assign room = (cnt_pop + {1'b0, pend_r}) < vps_pkg::FILL_MAX;
    assign at_end = (addr_r == end_addr);
    // no new read once run drops, only the one in flight completes
    assign step = tick & room & run & (state_r == vps_pkg::ST_RUN);

    // state, counter and loop register next values
    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        loop_nxt = tick ? loop_addr : loop_r;
        case (state_r)
            vps_pkg::ST_IDLE: begin
                if (run) begin
                    state_nxt = vps_pkg::ST_RUN;
                    addr_nxt = start_addr;
                end
            end
            vps_pkg::ST_RUN: begin
                if (!run) begin
                    state_nxt = vps_pkg::ST_IDLE;
                end else if (step) begin
                    // reload keeps the loop seamless
                    addr_nxt = at_end ? loop_r : addr_r + 18'h00001;
                end
            end
            default: state_nxt = vps_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= vps_pkg::ST_IDLE;
            addr_r <= '0;
            loop_r <= '0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            loop_r <= loop_nxt;
        end
    end

    // ---------------------------------------------------------------
    // output buffer and channel muxes
    // ---------------------------------------------------------------
    // two entries; head is the output register, read in flight lands in head if empty after pop, else second
    always_comb begin
        pend_nxt = step;
        e0_nxt = e0_r;
        e1_nxt = e1_r;
        if (pop) begin
            e0_nxt = e1_r;
        end
        if (pend_r) begin
            if (cnt_pop == 2'h0) begin
                e0_nxt = chan_mux(mif.rd_data, chan_en);
            end else begin
                e1_nxt = chan_mux(mif.rd_data, chan_en);
            end
        end
        cnt_nxt = cnt_pop + {1'b0, pend_r};
        busy_nxt = (state_nxt == vps_pkg::ST_RUN) | pend_nxt | (cnt_nxt != 2'h0);
        valid_nxt = (cnt_nxt != 2'h0);                    // head holds a vector
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_r <= 1'b0;
            cnt_r <= '0;
            e0_r <= '0;
            e1_r <= '0;
            busy_r <= 1'b0;
            valid_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
            cnt_r <= cnt_nxt;
            e0_r <= e0_nxt;
            e1_r <= e1_nxt;
            busy_r <= busy_nxt;
            valid_r <= valid_nxt;
        end
    end

    // ---------------------------------------------------------------
    // clock out delay
    // ---------------------------------------------------------------
    // tick history is the tap bank, delay_sel picks one tap
    always_comb begin
        tap_nxt = {tap_r[vps_pkg::TAPS-2:0], tick};
        clk_out_nxt = tap_r[delay_sel];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tap_r <= '0;
            clk_out_r <= 1'b0;
        end else begin
            tap_r <= tap_nxt;
            clk_out_r <= clk_out_nxt;
        end
    end

    assign out_valid = valid_r;
    assign out_data = e0_r;
    assign clk_out = clk_out_r;
    assign busy = busy_r;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // a step on the last vector while still running
    sequence s_step_at_end;
        step && at_end && run;
    endsequence
    // counter now holds what the loop register held
    sequence s_reload;
        addr_r == $past(loop_r);
    endsequence

    chk_wrap_to_loop: assert property (s_step_at_end |=> s_reload)
        else $error("counter did not reload from loop register");
    chk_addr_increment: assert property (
        step && !at_end && run |=> addr_r == $past(addr_r) + 18'h00001)
        else $error("counter did not step by one");
    chk_restart_start: assert property (
        state_r == vps_pkg::ST_IDLE && run |=> addr_r == $past(start_addr))
        else $error("restart not from listing start");
    chk_stop_no_step: assert property (state_r == vps_pkg::ST_IDLE |-> !step)
        else $error("counter stepped while stopped");
    chk_read_lands: assert property (step |=> pend_r ##1 (cnt_r != 2'h0))
        else $error("read vector not buffered");
    chk_buf_no_overflow: assert property (
        cnt_r <= vps_pkg::FILL_MAX && !(pend_r && cnt_pop == 2'h2))
        else $error("output buffer overflow");
    // judged only while the quarter rate stays selected for the whole gap
    chk_low_rate_gap: assert property (
        rate_sel == vps_pkg::RATE_LOW && tick ##1 rate_sel == vps_pkg::RATE_LOW [*3]
        |-> !tick && !$past(tick) && !$past(tick, 2))
        else $error("quarter rate tick spacing wrong");
    chk_ext_edge_tick: assert property (
        rate_sel == vps_pkg::RATE_EXT && tick |-> ext_r[1] && !ext_r[2])
        else $error("external tick without edge");
    chk_clk_out_tap0: assert property (
        tick && delay_sel == 3'h0 ##1 delay_sel == 3'h0 |=> clk_out_r)
        else $error("clock out tap zero late");
    // top channel is one of the sixteen the bench disables
    chk_chan_disabled: assert property (
        pend_r && cnt_pop == 2'h0 && !chan_en[CH-1] |=> !out_data[CH-1])
        else $error("disabled channel not idle");
endmodule
`default_nettype wire

//--- verif/vps_rx_model.sv
// receiver model standing at the vector output, with an optional stall pattern
`timescale 1ns/1ps
`default_nettype none
module vps_rx_model (
    input wire logic clk,              // system clock
    input wire logic rst_b,            // async reset, low
    input wire logic out_valid,        // vector offered
    input wire logic [31:0] out_data,  // offered vector
    input wire logic slow,             // stall two cycles of every three
    output logic out_ready             // vector taken this cycle
);
    logic [31:0] seen[$];              // vectors accepted, in order
    logic [1:0] cnt_r;                 // stall pattern phase
    // ---------------------------------------------------------------
    // accept on valid and ready, stepping the stall phase each cycle
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 2'h0;
        end else begin
            cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
            if (out_valid && out_ready) begin
                seen.push_back(out_data);
            end
        end
    end
    // ready changes only just after an edge, so it is steady when sampled
    assign out_ready = !slow || (cnt_r == 2'h0);
endmodule
`default_nettype wire

//--- verif/vector_pattern_sequencer_bench.sv
// self-checking bench for the vector pattern sequencer
`timescale 1ns/1ps
`default_nettype none
module vector_pattern_sequencer_bench;
    logic clk, rst_b, prog_we, run, ext_clk, out_ready, out_valid, clk_out, busy, slow;
    logic [vps_pkg::ADDR_W-1:0] prog_addr, start_addr, end_addr, loop_addr;
    logic [vps_pkg::WORD_W-1:0] prog_data;
    logic [1:0] rate_sel;
    logic [vps_pkg::TAP_W-1:0] delay_sel;
    logic [31:0] chan_en, out_data;
    int miscompares = 0;  // mismatches seen
    int num_checks = 0;   // comparisons made
    int cyc = 0;          // clock cycles since time zero
    vps_sequencer vps_sequencer_i (.clk(clk), .rst_b(rst_b), .prog_we(prog_we),
        .prog_addr(prog_addr), .prog_data(prog_data), .run(run), .start_addr(start_addr),
        .end_addr(end_addr), .loop_addr(loop_addr), .rate_sel(rate_sel),
        .delay_sel(delay_sel), .chan_en(chan_en), .ext_clk(ext_clk), .out_ready(out_ready),
        .out_valid(out_valid), .out_data(out_data), .clk_out(clk_out), .busy(busy));
    vps_rx_model vps_rx_model_i (.clk(clk), .rst_b(rst_b), .out_valid(out_valid),
        .out_data(out_data), .slow(slow), .out_ready(out_ready));
    // ---------------------------------------------------------------
    // clocks and hang guard
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // external clock of 60 ns, kept off the system edges
    initial begin
        ext_clk = 1'b0;
        #3;
        forever #30 ext_clk = ~ext_clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            end_of_test();
        end
    end
    // ---------------------------------------------------------------
    // shared helpers
    // ---------------------------------------------------------------
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // stored word pattern: low 16 bits name the address, top 16 bits are 5A3C
    function automatic logic [31:0] pat(input int a);
        return 32'h5A3C_0000 | 32'(a);
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // play a listing, collect n vectors, stop, and compare against the walk
    task automatic play(input int s, input int e, input int l, input int n);
        int a;
        int k;
        vps_rx_model_i.seen.delete();
        start_addr = 18'(s);
        end_addr = 18'(e);
        loop_addr = 18'(l);
        run = 1'b1;
        for (k = 0; k < 3000 && vps_rx_model_i.seen.size() < n; k++) step();
        run = 1'b0;
        for (k = 0; k < 300 && busy !== 1'b0; k++) step();
        check({31'h0, busy}, 32'h0);
        check(32'(vps_rx_model_i.seen.size() >= n), 32'h1);
        a = s;
        for (k = 0; k < n && k < vps_rx_model_i.seen.size(); k++) begin
            check(vps_rx_model_i.seen[k], pat(a) & chan_en);
            a = (a == e) ? l : a + 1;
        end
    endtask
    // spacing of clock out pulses while running at a given rate
    task automatic spacing(input logic [1:0] r, input int exp);
        int k;
        int t0;
        rate_sel = r;
        run = 1'b1;
        repeat (12) step();
        for (k = 0; k < 50 && clk_out !== 1'b1; k++) step();
        for (k = 0; k < 50 && clk_out !== 1'b0; k++) step();
        for (k = 0; k < 50 && clk_out !== 1'b1; k++) step();
        t0 = cyc;
        step();
        for (k = 0; k < 50 && clk_out !== 1'b1; k++) step();
        check(32'(cyc - t0), 32'(exp));
        run = 1'b0;
        for (k = 0; k < 300 && busy !== 1'b0; k++) step();
    endtask
    // phase of the first clock out pulse after sixteen cycles, modulo the quarter-rate period
    task automatic phase(input logic [2:0] d, output int p);
        int k;
        delay_sel = d;
        run = 1'b1;
        repeat (16) step();
        for (k = 0; k < 50 && clk_out !== 1'b0; k++) step();
        for (k = 0; k < 50 && clk_out !== 1'b1; k++) step();
        p = cyc % 4;
        run = 1'b0;
        for (k = 0; k < 300 && busy !== 1'b0; k++) step();
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        int p0;
        int p3;
        rst_b = 1'b0;
        {prog_we, run, slow} = 3'h0;
        {prog_addr, start_addr, end_addr, loop_addr} = '0;
        prog_data = '0;
        rate_sel = vps_pkg::RATE_SRC;
        delay_sel = 3'h0;
        chan_en = 32'hFFFF_FFFF;
        repeat (6) @(posedge clk);
        #1;
        rst_b = 1'b1;
        check({30'h0, out_valid, busy}, 32'h0);
        // back to back host writes of twelve words
        for (int i = 0; i < 12; i++) begin
            prog_we = 1'b1;
            prog_addr = 18'(i);
            prog_data = {48'hF0F0_0F0F_A5A5, pat(i)};
            step();
        end
        prog_we = 1'b0;
        play(2, 5, 2, 10);
        play(0, 3, 6, 8);
        slow = 1'b1;
        play(1, 4, 1, 9);
        slow = 1'b0;
        chan_en = 32'h0000_FFFF;
        play(3, 4, 3, 5);
        chan_en = 32'hFFFF_FFFF;
        spacing(vps_pkg::RATE_MID, 2);
        spacing(vps_pkg::RATE_LOW, 4);
        spacing(vps_pkg::RATE_EXT, 6);
        rate_sel = vps_pkg::RATE_LOW;
        phase(3'h0, p0);
        phase(3'h3, p3);
        check(32'(p3), 32'((p0 + 3) % 4));
        end_of_test();
    end
endmodule
`default_nettype wire
